// File: birp_card_model.sv
/* birp_card_model: pci cards and onboard peripherals driving the interrupt pins.
   Assumes the bench changes requests just after a clock edge. */
`timescale 1ns/1ns
module birp_card_model (
  // requests, active high
  input  wire logic [11:0]    i_slot_req,
  input  wire logic [4:0]     i_low_req,
  input  wire logic [7:0]     i_leg_req,
  input  wire logic [15:0]    i_isa_req,
  // board pins
  output birp_pkg::birp_src_s o_src
);
  // a card may pull any of its four pins, not only pin A
  always_comb begin
    o_src = birp_pkg::SRC_IDLE;
    {o_src.slot3_n, o_src.slot2_n, o_src.slot1_n} = ~i_slot_req;
    {o_src.net_n, o_src.stor_n, o_src.gfx_n, o_src.rtc_n, o_src.abort_n} = ~i_low_req;
    {o_src.kbd, o_src.com1, o_src.com2, o_src.fdc} = i_leg_req[7:4];
    {o_src.lpt, o_src.audio, o_src.mouse, o_src.ide} = i_leg_req[3:0];
    o_src.isa = i_isa_req;
  end
endmodule : birp_card_model

// File: birp_pkg.sv
/*
 * birp_pkg: shared types and constants for the board interrupt routing and
 * priority block. Assumes one 100 MHz clock and synchronous pin sampling.
 */
package birp_pkg;

  // pin positions within a slot's four-bit group
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  localparam int NUM_IRQ   = 16;
  localparam int NUM_LINES = 4;
  localparam int NUM_PRIO  = 15;

  typedef logic [3:0] birp_irq_t;
  typedef logic [NUM_LINES-1:0][3:0] birp_steer_t;

  // shared pci line to irq steering after reset: lines 0,1 -> 9, lines 2,3 -> 11
  localparam birp_steer_t STEER_RST = {4'hB, 4'hB, 4'h9, 4'h9};

  // fixed irq numbers of the onboard legacy sources
  localparam birp_irq_t IRQ_TIMER   = 4'h0;
  localparam birp_irq_t IRQ_KBD     = 4'h1;
  localparam birp_irq_t IRQ_CASCADE = 4'h2;
  localparam birp_irq_t IRQ_COM2    = 4'h3;
  localparam birp_irq_t IRQ_COM1    = 4'h4;
  localparam birp_irq_t IRQ_FDC     = 4'h6;
  localparam birp_irq_t IRQ_LPT     = 4'h7;
  localparam birp_irq_t IRQ_RTC     = 4'h8;
  localparam birp_irq_t IRQ_AUDIO   = 4'hA;
  localparam birp_irq_t IRQ_MOUSE   = 4'hC;
  localparam birp_irq_t IRQ_FREE    = 4'hD;
  localparam birp_irq_t IRQ_IDE     = 4'hE;

  // highest priority first; irq2 stands for the whole 8..15 group
  localparam birp_irq_t [0:NUM_PRIO-1] PRIO_ORDER = {
    4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
    4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  // external interrupt pins, as seen on the board
  typedef struct packed {
    logic [3:0]  slot3_n;
    logic [3:0]  slot2_n;
    logic [3:0]  slot1_n;
    logic        net_n;
    logic        stor_n;
    logic        gfx_n;
    logic        rtc_n;
    logic        abort_n;
    logic        kbd;
    logic        com1;
    logic        com2;
    logic        fdc;
    logic        lpt;
    logic        audio;
    logic        mouse;
    logic        ide;
    logic [15:0] isa;
  } birp_src_s;

  localparam birp_src_s SRC_IDLE = '{slot3_n: 4'hF, slot2_n: 4'hF,
    slot1_n: 4'hF, net_n: 1'b1, stor_n: 1'b1, gfx_n: 1'b1, rtc_n: 1'b1,
    abort_n: 1'b1, default: '0};

endpackage : birp_pkg

// File: birp_top.sv
/*
 * birp_top: board interrupt routing and priority logic. Combines the slot
 * and onboard pci interrupts onto four shared lines, steers them onto irqs,
 * detects legacy edges and reports the highest-priority pending irq.
 * Assumes all pins synchronous to I_CLK; the controller acknowledges the
 * serviced irq with a one-cycle I_ACK.
 */
`timescale 1ns/1ns
module birp_top (
  // clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RESET_N,
  // interrupt sources
  input  wire birp_pkg::birp_src_s I_SRC,
  input  wire logic                I_TIMER0,
  // steering load
  input  wire logic                I_STEER_WE,
  input  wire birp_pkg::birp_steer_t I_STEER_MAP,
  // acknowledge from the controller
  input  wire logic                I_ACK,
  input  wire birp_pkg::birp_irq_t I_ACK_IRQ,
  // to the controller
  output logic [15:0]              O_IRQ_REQ,
  output logic [15:0]              O_IRQ_EDGE,
  output logic [15:0]              O_LEVEL_MODE,
  output logic [15:0]              O_PENDING,
  output logic                     O_CASCADE,
  output logic                     O_ACT_VALID,
  output birp_pkg::birp_irq_t      O_ACT_IRQ
);

  typedef struct packed {
    birp_pkg::birp_src_s   sync1;
    birp_pkg::birp_src_s   sync2;
    birp_pkg::birp_steer_t steer;
    logic [15:0]           prev;
    logic [15:0]           edge_pend;
    logic [15:0]           irq_req;
    logic [15:0]           irq_edge;
    logic [15:0]           level_mode;
    logic [15:0]           pending;
    logic                  cascade;
    logic                  act_valid;
    birp_pkg::birp_irq_t   act_irq;
  } birp_state_s;

  localparam birp_state_s STATE_RST = '{
    sync1: birp_pkg::SRC_IDLE, sync2: birp_pkg::SRC_IDLE,
    steer: birp_pkg::STEER_RST, act_irq: 4'h0, default: '0};

  birp_state_s q;
  birp_state_s d;
  logic [3:0]  line_n;
  logic [15:0] pci_irq;
  logic [15:0] lvl_map;
  logic [15:0] raw;
  logic [15:0] req;
  logic [15:0] rise;
  logic [15:0] eff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // only the second stage ever reads the first
    d.sync1 = I_SRC;
    d.sync2 = q.sync1;
    if (I_STEER_WE) begin
      d.steer = I_STEER_MAP;
    end

    // wired-and of open-drain pins; several card pins share each of lines 0 to 2, line 3 takes gfx only
    line_n[0] = q.sync2.net_n & q.sync2.slot1_n[birp_pkg::PIN_A]
              & q.sync2.slot2_n[birp_pkg::PIN_D]
              & q.sync2.slot3_n[birp_pkg::PIN_C];
    line_n[1] = q.sync2.slot1_n[birp_pkg::PIN_B]
              & q.sync2.slot2_n[birp_pkg::PIN_A]
              & q.sync2.slot3_n[birp_pkg::PIN_D];
    line_n[2] = q.sync2.stor_n
              & q.sync2.slot1_n[birp_pkg::PIN_C]
              & q.sync2.slot1_n[birp_pkg::PIN_D]
              & q.sync2.slot2_n[birp_pkg::PIN_B]
              & q.sync2.slot2_n[birp_pkg::PIN_C]
              & q.sync2.slot3_n[birp_pkg::PIN_A]
              & q.sync2.slot3_n[birp_pkg::PIN_B];
    line_n[3] = q.sync2.gfx_n;

    // several lines may share one irq
    pci_irq = '0;
    lvl_map = '0;
    for (int k = 0; k < birp_pkg::NUM_LINES; k++) begin
      pci_irq[q.steer[k]] = pci_irq[q.steer[k]] | ~line_n[k];
      lvl_map[q.steer[k]] = 1'b1;
    end

    // legacy sources, normalised to active high
    raw = q.sync2.isa;
    raw[birp_pkg::IRQ_CASCADE] = 1'b0;
    raw[birp_pkg::IRQ_TIMER] = I_TIMER0;
    raw[birp_pkg::IRQ_KBD]   = q.sync2.kbd;
    raw[birp_pkg::IRQ_COM2]  = q.sync2.com2 | q.sync2.isa[birp_pkg::IRQ_COM2];
    raw[birp_pkg::IRQ_COM1]  = q.sync2.com1 | q.sync2.isa[birp_pkg::IRQ_COM1];
    raw[birp_pkg::IRQ_FDC]   = q.sync2.fdc | q.sync2.isa[birp_pkg::IRQ_FDC];
    raw[birp_pkg::IRQ_LPT]   = q.sync2.lpt | q.sync2.isa[birp_pkg::IRQ_LPT];
    // falling edge on either pin while the other is high is a rising edge after inversion
    raw[birp_pkg::IRQ_RTC]   = ~(q.sync2.rtc_n & q.sync2.abort_n);
    raw[birp_pkg::IRQ_AUDIO] = q.sync2.audio | q.sync2.isa[birp_pkg::IRQ_AUDIO];
    raw[birp_pkg::IRQ_MOUSE] = q.sync2.mouse | q.sync2.isa[birp_pkg::IRQ_MOUSE];
    raw[birp_pkg::IRQ_IDE]   = q.sync2.ide | q.sync2.isa[birp_pkg::IRQ_IDE];
    raw[birp_pkg::IRQ_FREE]  = q.sync2.isa[birp_pkg::IRQ_FREE];

    // legacy and pci never share an irq if firmware behaves; or-ing is safe
    req  = raw | pci_irq;
    rise = req & ~q.prev & ~lvl_map;
    d.prev = req;

    // set wins over acknowledge in the same cycle
    d.edge_pend = q.edge_pend;
    if (I_ACK) begin
      d.edge_pend[I_ACK_IRQ] = 1'b0;
    end
    d.edge_pend = (d.edge_pend | rise) & ~lvl_map;

    // level irqs are pending exactly while the line is held
    eff = (q.edge_pend & ~q.level_mode) | (q.irq_req & q.level_mode);
    eff[birp_pkg::IRQ_CASCADE] = |eff[15:8];

    d.act_valid = 1'b0;
    d.act_irq   = 4'h0;
    for (int i = birp_pkg::NUM_PRIO - 1; i >= 0; i--) begin
      if (eff[birp_pkg::PRIO_ORDER[i]]) begin
        d.act_valid = 1'b1;
        d.act_irq   = birp_pkg::PRIO_ORDER[i];
      end
    end

    d.irq_req    = req;
    d.irq_edge   = rise;
    d.level_mode = lvl_map;
    d.pending    = eff;
    d.cascade    = eff[birp_pkg::IRQ_CASCADE];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign O_IRQ_REQ    = q.irq_req;
  assign O_IRQ_EDGE   = q.irq_edge;
  assign O_LEVEL_MODE = q.level_mode;
  assign O_PENDING    = q.pending;
  assign O_CASCADE    = q.cascade;
  assign O_ACT_VALID  = q.act_valid;
  assign O_ACT_IRQ    = q.act_irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_line_zero: assert property (!line_n[0] |=> O_IRQ_REQ[$past(q.steer[0])])
    else $error("line zero not forwarded");
  a_line_one: assert property (!line_n[1] |=> O_IRQ_REQ[$past(q.steer[1])])
    else $error("line one not forwarded");
  a_line_two: assert property (!q.sync2.stor_n |-> !line_n[2] ##1 O_IRQ_REQ[$past(q.steer[2])])
    else $error("line two not forwarded");
  a_steer_load: assert property (I_STEER_WE |=> q.steer == $past(I_STEER_MAP))
    else $error("steering not loaded");
  a_three_lines: assert property (q.sync2.slot1_n[2:0] == 3'h0 |-> line_n[2:0] == 3'h0)
    else $error("card pins do not reach three lines");
  a_timer_top: assert property (O_PENDING[0] |-> O_ACT_VALID && O_ACT_IRQ == 4'h0)
    else $error("irq0 not top priority");
  a_slave_prio: assert property (O_PENDING[8] && O_PENDING[3] && !O_PENDING[0] && !O_PENDING[1]
      |-> O_ACT_IRQ == 4'h8 && O_CASCADE)
    else $error("slave group not above irq3");
  a_rtc_fall: assert property ($fell(q.sync2.rtc_n) && q.sync2.abort_n && !lvl_map[8] && !q.prev[8]
      |=> O_IRQ_EDGE[8])
    else $error("rtc falling edge missed");
  a_kbd_map: assert property ($rose(q.sync2.kbd) && !lvl_map[1] |=> O_IRQ_EDGE[1] ##1 !O_IRQ_EDGE[1])
    else $error("keyboard edge not single pulse");
  a_free_irq: assert property (!q.sync2.isa[13] && !lvl_map[13] |=> !O_IRQ_REQ[13])
    else $error("irq13 driven without source");
  a_sync_two: assert property ($past(I_RESET_N, 2) |-> q.sync2 == $past(I_SRC, 2))
    else $error("synchroniser depth wrong");
  a_sync_one: assert property ($past(I_RESET_N) |-> q.sync1 == $past(I_SRC))
    else $error("first synchroniser stage wrong");

  // shared lines and their steering
  a_line_three: assert property (!line_n[3] |=> O_IRQ_REQ[$past(q.steer[3])])
    else $error("line three not forwarded");
  a_level_line0: assert property (1'b1 |=> O_LEVEL_MODE[$past(q.steer[0])])
    else $error("line zero irq not level");
  a_level_line1: assert property (1'b1 |=> O_LEVEL_MODE[$past(q.steer[1])])
    else $error("line one irq not level");
  a_level_line2: assert property (1'b1 |=> O_LEVEL_MODE[$past(q.steer[2])])
    else $error("line two irq not level");
  a_level_line3: assert property (1'b1 |=> O_LEVEL_MODE[$past(q.steer[3])])
    else $error("line three irq not level");
  a_level_pend: assert property (O_LEVEL_MODE[11] && O_IRQ_REQ[11]
      |=> O_PENDING[11])
    else $error("held level irq not pending");
  a_level_no_edge: assert property ((O_LEVEL_MODE & O_IRQ_EDGE) == 16'h0000)
    else $error("edge reported on a level irq");
  a_slot3_lines: assert property (q.sync2.slot3_n == 4'h0
      |-> line_n[2:0] == 3'h0)
    else $error("third card pins do not reach three lines");

  // edge capture and acknowledge
  a_timer_edge: assert property ($rose(I_TIMER0) && !lvl_map[0] && !q.prev[0]
      |=> O_IRQ_EDGE[0])
    else $error("timer edge missed");
  a_edge_once: assert property (1'b1 |=> (O_IRQ_EDGE & $past(O_IRQ_EDGE)) == 16'h0000)
    else $error("edge pulse longer than one cycle");
  a_ack_clears: assert property (I_ACK && !rise[I_ACK_IRQ]
      |=> !q.edge_pend[$past(I_ACK_IRQ)])
    else $error("acknowledge did not clear pending edge");
  a_set_wins: assert property (I_ACK && rise[I_ACK_IRQ]
      |=> q.edge_pend[$past(I_ACK_IRQ)])
    else $error("new edge lost to acknowledge");
  a_abort_fall: assert property ($fell(q.sync2.abort_n) && q.sync2.rtc_n
      && !lvl_map[8] && !q.prev[8] |=> O_IRQ_EDGE[8])
    else $error("abort falling edge missed");

  // fixed onboard legacy wiring
  a_com2_map: assert property ($rose(q.sync2.com2) && !lvl_map[3] && !q.prev[3]
      |=> O_IRQ_EDGE[3])
    else $error("second serial port edge missed");
  a_com1_map: assert property ($rose(q.sync2.com1) && !lvl_map[4] && !q.prev[4]
      |=> O_IRQ_EDGE[4])
    else $error("first serial port edge missed");
  a_fdc_map: assert property ($rose(q.sync2.fdc) && !lvl_map[6] && !q.prev[6]
      |=> O_IRQ_EDGE[6])
    else $error("floppy edge missed");
  a_lpt_map: assert property ($rose(q.sync2.lpt) && !lvl_map[7] && !q.prev[7]
      |=> O_IRQ_EDGE[7])
    else $error("parallel port edge missed");
  a_audio_map: assert property ($rose(q.sync2.audio) && !lvl_map[10] && !q.prev[10]
      |=> O_IRQ_EDGE[10])
    else $error("audio edge missed");
  a_mouse_map: assert property ($rose(q.sync2.mouse) && !lvl_map[12] && !q.prev[12]
      |=> O_IRQ_EDGE[12])
    else $error("mouse edge missed");
  a_ide_map: assert property ($rose(q.sync2.ide) && !lvl_map[14] && !q.prev[14]
      |=> O_IRQ_EDGE[14])
    else $error("disk interface edge missed");
  a_free_edge: assert property ($rose(q.sync2.isa[13]) && !lvl_map[13] && !q.prev[13]
      |=> O_IRQ_EDGE[13])
    else $error("irq13 edge missed");

  // priority outcome, against a rank table kept apart from the encoder
  a_no_irq2_act: assert property (O_ACT_VALID |-> O_ACT_IRQ != 4'h2)
    else $error("cascade irq reported as active");
  a_cascade_any: assert property (O_CASCADE == (|O_PENDING[15:8]))
    else $error("cascade flag disagrees with slave group");
  a_act_valid: assert property (O_ACT_VALID == (|O_PENDING))
    else $error("active flag disagrees with pending set");

  // rank is priority minus one; irq2 never ranks, it only stands for 8..15
  function automatic logic [3:0] prio_rank(input logic [3:0] irq);
    logic [3:0] r;
    r = 4'hF;
    case (irq)
      4'h0: r = 4'h0;
      4'h1: r = 4'h1;
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: r = irq - 4'h6;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: r = irq + 4'h7;
      default: r = 4'hF;
    endcase
    return r;
  endfunction : prio_rank

  logic [3:0] best_rank;

  // checker only; lowest rank among the reported pending irqs
  always_comb begin
    best_rank = 4'hF;
    for (int j = 0; j < birp_pkg::NUM_IRQ; j++) begin
      if (O_PENDING[j] && (j != 2) && (prio_rank(4'(j)) < best_rank)) begin
        best_rank = prio_rank(4'(j));
      end
    end
  end

  a_prio_best: assert property (O_ACT_VALID |-> prio_rank(O_ACT_IRQ) == best_rank)
    else $error("active irq is not the highest priority pending");

  c_pci_level: cover property (O_LEVEL_MODE[9] && O_PENDING[9]);
  c_cascade: cover property (O_CASCADE && O_ACT_IRQ == 4'hE);
  c_ack_set: cover property (I_ACK && |rise);
  c_steer: cover property (I_STEER_WE ##1 O_LEVEL_MODE[5]);
  c_free_edge: cover property (O_IRQ_EDGE[13]);

endmodule : birp_top

// File: board_interrupt_routing_priority_tb_top.sv
/* board_interrupt_routing_priority_tb_top: self-checking bench for birp_top.
   Assumes the card model drives the pins and the bench plays the controller. */
`timescale 1ns/1ns
module board_interrupt_routing_priority_tb_top;
  logic I_CLK, I_RESET_N, I_TIMER0, I_STEER_WE, I_ACK;
  logic [11:0] slot;
  logic [4:0]  low;
  logic [7:0]  leg;
  logic [15:0] isa, O_IRQ_REQ, O_IRQ_EDGE, O_LEVEL_MODE, O_PENDING;
  logic        O_CASCADE, O_ACT_VALID;
  birp_pkg::birp_src_s   src;
  birp_pkg::birp_steer_t I_STEER_MAP;
  birp_pkg::birp_irq_t   I_ACK_IRQ, O_ACT_IRQ;
  int fails = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////
  birp_card_model cards (.i_slot_req(slot), .i_low_req(low), .i_leg_req(leg), .i_isa_req(isa), .o_src(src));
  birp_top uut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_SRC(src), .I_TIMER0(I_TIMER0),
    .I_STEER_WE(I_STEER_WE), .I_STEER_MAP(I_STEER_MAP), .I_ACK(I_ACK), .I_ACK_IRQ(I_ACK_IRQ),
    .O_IRQ_REQ(O_IRQ_REQ), .O_IRQ_EDGE(O_IRQ_EDGE), .O_LEVEL_MODE(O_LEVEL_MODE),
    .O_PENDING(O_PENDING), .O_CASCADE(O_CASCADE), .O_ACT_VALID(O_ACT_VALID), .O_ACT_IRQ(O_ACT_IRQ));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask : step
  task automatic ack(input logic [3:0] v);
    @(posedge I_CLK) begin I_ACK <= 1'b1; I_ACK_IRQ <= v; end
    @(posedge I_CLK) I_ACK <= 1'b0;
  endtask : ack
  task automatic finish_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // each slot pin lands on its shared line, which default steering maps to 9 or 11
  task automatic pci_routing;
    logic [11:0] to11 = 12'h36C;
    for (int i = 0; i < 12; i++) begin
      @(posedge I_CLK) slot <= 12'h001 << i;
      step(4); chk(O_IRQ_REQ, to11[i] ? 16'h0800 : 16'h0200);
      @(posedge I_CLK) slot <= '0;
      step(4); chk(O_IRQ_REQ, 16'h0000);
    end
    @(posedge I_CLK) low <= 5'h10;
    step(4); chk(O_IRQ_REQ, 16'h0200);
    @(posedge I_CLK) low <= 5'h08;
    step(4); chk(O_IRQ_REQ, 16'h0800);
    @(posedge I_CLK) low <= 5'h04;
    step(4); chk(O_IRQ_REQ, 16'h0800);
    @(posedge I_CLK) low <= 5'h00;
    step(4); chk(O_IRQ_REQ, 16'h0000);
    chk(O_LEVEL_MODE, 16'h0A00);
  endtask : pci_routing
  // firmware keeps each pci irq free of legacy sources
  task automatic steering;
    @(posedge I_CLK) begin I_STEER_WE <= 1'b1; I_STEER_MAP <= {4'hF, 4'hB, 4'h9, 4'h5}; end
    @(posedge I_CLK) begin I_STEER_WE <= 1'b0; slot <= 12'hD00; end
    step(4); chk(O_IRQ_REQ, 16'h0A20);
    chk(O_LEVEL_MODE, 16'h8A20);
    @(posedge I_CLK) begin I_STEER_WE <= 1'b1; I_STEER_MAP <= birp_pkg::STEER_RST; slot <= '0; end
    @(posedge I_CLK) I_STEER_WE <= 1'b0;
    step(5); chk(O_LEVEL_MODE, 16'h0A00);
    chk(O_IRQ_REQ, 16'h0000);
  endtask : steering
  task automatic legacy;
    logic [3:0] irq [8] = '{4'h1, 4'h4, 4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE};
    for (int i = 0; i < 8; i++) begin
      @(posedge I_CLK) leg <= 8'h80 >> i;
      step(3); chk(O_IRQ_EDGE, 16'h0001 << irq[i]);
      step(1); chk(O_PENDING, (16'h0001 << irq[i]) | (irq[i] > 7 ? 16'h0004 : 16'h0000));
      chk({12'h000, O_ACT_IRQ}, {12'h000, irq[i]});
      chk({15'h0000, O_ACT_VALID}, 16'h0001);
      @(posedge I_CLK) leg <= '0;
      ack(irq[i]);
      step(3); chk(O_PENDING, 16'h0000);
      chk({15'h0000, O_ACT_VALID}, 16'h0000);
    end
  endtask : legacy
  // timer, keyboard, clock, free slot irq and com2 at once, served in priority order
  task automatic priority_order;
    logic [3:0] ord [5] = '{4'h0, 4'h1, 4'h8, 4'hD, 4'h3};
    @(posedge I_CLK) begin I_TIMER0 <= 1'b1; leg <= 8'h80; low <= 5'h02; isa <= 16'h2008; end
    step(5); chk(O_PENDING, 16'h210F);
    chk({15'h0000, O_CASCADE}, 16'h0001);
    @(posedge I_CLK) begin I_TIMER0 <= 1'b0; leg <= '0; low <= '0; isa <= '0; end
    for (int i = 0; i < 5; i++) begin
      step(2); chk({12'h000, O_ACT_IRQ}, {12'h000, ord[i]});
      ack(ord[i]);
    end
    step(2); chk(O_PENDING, 16'h0000);
    chk({15'h0000, O_ACT_VALID}, 16'h0000);
  endtask : priority_order
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    I_RESET_N = 1'b0; I_TIMER0 = 1'b0; I_STEER_WE = 1'b0; I_STEER_MAP = birp_pkg::STEER_RST;
    I_ACK = 1'b0; I_ACK_IRQ = '0; slot = '0; low = '0; leg = '0; isa = '0;
    step(11); chk(O_IRQ_REQ | O_PENDING, 16'h0000);
    @(posedge I_CLK) I_RESET_N <= 1'b1;
    step(4);
    pci_routing();
    steering();
    legacy();
    priority_order();
    finish_test();
  end
endmodule : board_interrupt_routing_priority_tb_top
